// *** src/usb_device_status_frame_regs.v ***
// Purpose: Device status and frame number registers of both device units.
// Assumes: Event inputs are one-cycle pulses on ref_clk; the supply and
//          identification levels come straight from pins.
// Notes:   Two register ports, on-chip processor and host parallel port,
//          each with registered read data one cycle after rd.
// What this block does
// - Status flags clear on writing one
// - Host parallel port also reads and clears
// - Supply flag sets on both 4.4V crossings
// - Supply and ID flags only in unit one
// - ID flag sets on both pin edges
// - Bit 9 sets on frame marker
// - Bit 8 sets on bus reset
// - Bits 7..0 set on endpoint transaction end
// - Enabled NAK also sets endpoint flag
// - Frame register holds last frame number
// - Bit 15 shows frame timeout occurred
// - Frame register counts timeouts since marker
// - Counter 0..7, cleared by marker, gated by enable
// - Frame field kept on timeout, low speed
// - 12 MHz down counter expiry means timeout
// - Interrupt only when enable bit set
`timescale 1ns/100ps
`include "usb_dev_status_map.vh"
module usb_device_status_frame_regs
(
   input wire ref_clk,
   input wire rst,
   // On-chip processor register port
   input wire [15:0] cpu_addr,
   input wire cpu_wr,
   input wire cpu_rd,
   input wire [15:0] cpu_wdata,
   output reg [15:0] cpu_rdata,
   // host_parallel_port register port
   input wire [15:0] host_parallel_port_addr,
   input wire host_parallel_port_wr,
   input wire host_parallel_port_rd,
   input wire [15:0] host_parallel_port_wdata,
   output reg [15:0] host_parallel_port_rdata,
   // first_otg_port pins
   input wire supply_above_pin,
   input wire id_pin,
   // Device unit one events
   input wire [7:0] dev1_endpoint_n_done,
   input wire [7:0] dev1_endpoint_n_nak,
   input wire [7:0] dev1_nak_event_enable,
   input wire dev1_bus_reset,
   input wire dev1_sof,
   input wire dev1_eop,
   input wire [10:0] dev1_frame_in,
   input wire dev1_full_speed,
   input wire [13:0] dev1_sof_count,
   input wire [15:0] dev1_int_enable,
   // Device unit two events
   input wire [7:0] dev2_endpoint_n_done,
   input wire [7:0] dev2_endpoint_n_nak,
   input wire [7:0] dev2_nak_event_enable,
   input wire dev2_bus_reset,
   input wire dev2_sof,
   input wire dev2_eop,
   input wire [10:0] dev2_frame_in,
   input wire dev2_full_speed,
   input wire [13:0] dev2_sof_count,
   input wire [15:0] dev2_int_enable,
   // Processor interrupt requests
   output reg dev1_irq,
   output reg dev2_irq
);

// ----------------------------------------
// Declarations
// ----------------------------------------
reg [15:0] status1;
reg [15:0] status2;
reg [15:0] next_status1;
reg [15:0] next_status2;
reg [15:0] set1;
reg [15:0] set2;
reg [15:0] clear1;
reg [15:0] clear2;
reg [`TICK_ACC_WIDTH-1:0] tick_acc;
reg tick;
wire [15:0] frame1;
wire [15:0] frame2;
wire timeout1;
wire timeout2;
wire supply_level;
wire supply_change;
wire id_level;
wire id_change;
wire marker1;
wire marker2;
wire [`TICK_ACC_WIDTH-1:0] acc_step;
wire [`TICK_ACC_WIDTH-1:0] acc_sum;

assign marker1 = dev1_sof | dev1_eop;
assign marker2 = dev2_sof | dev2_eop;

// ----------------------------------------
// 12 MHz tick from 125 MHz
// ----------------------------------------
// Fractional step keeps the mean rate exact; jitter of one cycle
// per tick is far below any sensible timeout margin.
// Eight accumulator bits: the sum reaches 136 before the limit test.
assign acc_step = `TICK_RATE_MHZ;
assign acc_sum = tick_acc + acc_step;

always @(posedge ref_clk)
begin
   if (rst)
   begin
      tick_acc <= {`TICK_ACC_WIDTH{1'b0}};
      tick <= 1'b0;
   end
   else if (acc_sum >= `CLK_RATE_MHZ)
   begin
      tick_acc <= acc_sum - `CLK_RATE_MHZ;
      tick <= 1'b1;
   end
   else
   begin
      tick_acc <= acc_sum;
      tick <= 1'b0;
   end
end

// ----------------------------------------
// first_otg_port pin watchers
// ----------------------------------------
// A pin already high at reset gives one event after release
pin_event_sync supply_sync
(
   .ref_clk(ref_clk),
   .rst(rst),
   .pin(supply_above_pin),
   .level(supply_level),
   .change(supply_change)
);

pin_event_sync id_sync
(
   .ref_clk(ref_clk),
   .rst(rst),
   .pin(id_pin),
   .level(id_level),
   .change(id_change)
);

// ----------------------------------------
// Frame number units
// ----------------------------------------
// Both units share one tick; markers, frame inputs, speed, enables and reload counts are per unit
frame_timeout_unit frame_unit1
(
   .ref_clk(ref_clk),
   .rst(rst),
   .tick(tick),
   .marker(marker1),
   .sof(dev1_sof),
   .frame_in(dev1_frame_in),
   .full_speed(dev1_full_speed),
   .reload_count(dev1_sof_count),
   .timeout_en(dev1_int_enable[`BIT_TIMEOUT_ENABLE]),
   .frame_reg(frame1),
   .timeout(timeout1)
);

frame_timeout_unit frame_unit2
(
   .ref_clk(ref_clk),
   .rst(rst),
   .tick(tick),
   .marker(marker2),
   .sof(dev2_sof),
   .frame_in(dev2_frame_in),
   .full_speed(dev2_full_speed),
   .reload_count(dev2_sof_count),
   .timeout_en(dev2_int_enable[`BIT_TIMEOUT_ENABLE]),
   .frame_reg(frame2),
   .timeout(timeout2)
);

// ----------------------------------------
// Event set terms
// ----------------------------------------
always @*
begin
   set1 = 16'h0000;
   set1[7:0] = dev1_endpoint_n_done;
   set1[7:0] = set1[7:0] |
      (dev1_endpoint_n_nak & dev1_nak_event_enable);
   set1[`BIT_BUS_RESET] = dev1_bus_reset;
   set1[`BIT_FRAME_RX] = marker1;
   set1[`BIT_SUPPLY_EVENT] = supply_change;
   set1[`BIT_ID_EVENT] = id_change;
   set2 = 16'h0000;
   set2[7:0] = dev2_endpoint_n_done;
   set2[7:0] = set2[7:0] |
      (dev2_endpoint_n_nak & dev2_nak_event_enable);
   set2[`BIT_BUS_RESET] = dev2_bus_reset;
   set2[`BIT_FRAME_RX] = marker2;
end

// ----------------------------------------
// Write-one-to-clear from either port
// ----------------------------------------
// Both ports may clear in the same cycle; their masks simply merge.
always @*
begin
   clear1 = 16'h0000;
   clear2 = 16'h0000;
   if (cpu_wr && cpu_addr == `ADDR_STATUS_DEV1)
      clear1 = clear1 | cpu_wdata;
   else if (cpu_wr && cpu_addr == `ADDR_STATUS_DEV2)
      clear2 = clear2 | cpu_wdata;
   if (host_parallel_port_wr &&
       host_parallel_port_addr == `ADDR_STATUS_DEV1)
      clear1 = clear1 | host_parallel_port_wdata;
   else if (host_parallel_port_wr &&
            host_parallel_port_addr == `ADDR_STATUS_DEV2)
      clear2 = clear2 | host_parallel_port_wdata;
end

// Set beats clear, so an event in the clearing cycle survives
always @*
begin
   next_status1 = ((status1 & ~clear1) | set1) & `MASK_STATUS_DEV1;
   next_status2 = ((status2 & ~clear2) | set2) & `MASK_STATUS_DEV2;
end

always @(posedge ref_clk)
begin
   if (rst)
   begin
      status1 <= `RESET_STATUS;
      status2 <= `RESET_STATUS;
   end
   else
   begin
      status1 <= next_status1;
      status2 <= next_status2;
   end
end

// ----------------------------------------
// Interrupt requests
// ----------------------------------------
always @(posedge ref_clk)
begin
   if (rst)
   begin
      dev1_irq <= 1'b0;
      dev2_irq <= 1'b0;
   end
   else
   begin
      // Flags latch regardless; the enable only gates the request
      dev1_irq <= |(status1 & dev1_int_enable);
      dev2_irq <= |(status2 & dev2_int_enable);
   end
end

// ----------------------------------------
// Read data, one cycle after rd
// ----------------------------------------
always @(posedge ref_clk)
begin
   if (rst)
      cpu_rdata <= 16'h0000;
   // Zero between reads keeps stale status off the port
   else if (!cpu_rd)
      cpu_rdata <= 16'h0000;
   else if (cpu_addr == `ADDR_STATUS_DEV1)
      cpu_rdata <= status1;
   else if (cpu_addr == `ADDR_STATUS_DEV2)
      cpu_rdata <= status2;
   else if (cpu_addr == `ADDR_FRAME_DEV1)
      cpu_rdata <= frame1;
   else if (cpu_addr == `ADDR_FRAME_DEV2)
      cpu_rdata <= frame2;
   else
      cpu_rdata <= 16'h0000;
end

always @(posedge ref_clk)
begin
   if (rst)
      host_parallel_port_rdata <= 16'h0000;
   else if (!host_parallel_port_rd)
      host_parallel_port_rdata <= 16'h0000;
   else if (host_parallel_port_addr == `ADDR_STATUS_DEV1)
      host_parallel_port_rdata <= status1;
   else if (host_parallel_port_addr == `ADDR_STATUS_DEV2)
      host_parallel_port_rdata <= status2;
   else if (host_parallel_port_addr == `ADDR_FRAME_DEV1)
      host_parallel_port_rdata <= frame1;
   else if (host_parallel_port_addr == `ADDR_FRAME_DEV2)
      host_parallel_port_rdata <= frame2;
   else
      host_parallel_port_rdata <= 16'h0000;
end

endmodule // usb_device_status_frame_regs

// *** src/usb_dev_status_map.vh ***
// Purpose: Offsets, field positions, reset values and timing constants
//          of the device status and frame number registers.
// Assumes: 16-bit register port, byte addresses as printed.
// Notes:   Definitions only.
`ifndef USB_DEV_STATUS_MAP_VH
`define USB_DEV_STATUS_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_STATUS_DEV1 16'hC090
`define ADDR_FRAME_DEV1 16'hC092
`define ADDR_STATUS_DEV2 16'hC0B0
`define ADDR_FRAME_DEV2 16'hC0B2

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define BIT_SUPPLY_EVENT 15
`define BIT_ID_EVENT 14
`define BIT_FRAME_RX 9
`define BIT_BUS_RESET 8
`define MASK_STATUS_DEV1 16'hC3FF
`define MASK_STATUS_DEV2 16'h03FF
`define RESET_STATUS 16'h0000

// ----------------------------------------
// Frame number register fields
// ----------------------------------------
`define BIT_TIMEOUT_FLAG 15
`define TIMEOUT_CNT_MSB 14
`define TIMEOUT_CNT_LSB 12
`define FRAME_MSB 10
`define TIMEOUT_CNT_MAX 3'h7
`define RESET_FRAME 16'h0000
`define BIT_TIMEOUT_ENABLE 11

// ----------------------------------------
// Timing
// ----------------------------------------
`define SOF_COUNT_RESET 14'h2EE0
`define CLK_RATE_MHZ 8'h7D
`define TICK_RATE_MHZ 8'h0C
`define TICK_ACC_WIDTH 8

`endif

// *** src/pin_event_sync.v ***
// Purpose: Brings an asynchronous pin level into ref_clk and flags
//          every settled change of it.
// Assumes: Pin may change at any time relative to ref_clk.
// Notes:   Change is a one-cycle pulse from a flip-flop.
`timescale 1ns/100ps
module pin_event_sync
(
   input wire ref_clk,
   input wire rst,
   input wire pin,
   output reg level,
   output reg change
);

reg stage1;
reg stage2;
reg stage3;

// ----------------------------------------
// Three-stage capture, second and third must agree
// ----------------------------------------
always @(posedge ref_clk)
begin
   if (rst)
   begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
      change <= 1'b0;
   end
   else
   begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      change <= 1'b0;
      // Level after reset is learned like any other change, with an event
      if (stage2 == stage3 && stage3 != level)
      begin
         level <= stage3;
         change <= 1'b1;
      end
   end
end

endmodule // pin_event_sync

// *** src/frame_timeout_unit.v ***
// Purpose: Frame number capture and frame-marker timeout watch for one
//          device unit.
// Assumes: tick is a one-cycle pulse at the 12 MHz mean rate.
// Notes:   Output is the read image of the frame number register.
`timescale 1ns/100ps
`include "usb_dev_status_map.vh"
module frame_timeout_unit
(
   input wire ref_clk,
   input wire rst,
   input wire tick,
   input wire marker,
   input wire sof,
   input wire [10:0] frame_in,
   input wire full_speed,
   input wire [13:0] reload_count,
   input wire timeout_en,
   output reg [15:0] frame_reg,
   output reg timeout
);

reg [13:0] down;

// ----------------------------------------
// Down counter at 12 MHz
// ----------------------------------------
always @(posedge ref_clk)
begin
   if (rst)
   begin
      down <= `SOF_COUNT_RESET;
      timeout <= 1'b0;
   end
   else
   begin
      timeout <= 1'b0;
      if (marker)
         down <= reload_count;
      else if (tick)
      begin
         if (down == 14'h0000)
         begin
            timeout <= 1'b1;
            down <= reload_count;
         end
         else
            down <= down - 14'h0001;
      end
   end
end

// ----------------------------------------
// Register image
// ----------------------------------------
always @(posedge ref_clk)
begin
   if (rst)
      frame_reg <= `RESET_FRAME;
   else
   begin
      if (marker)
      begin
         // New marker ends the timeout episode
         frame_reg[`BIT_TIMEOUT_FLAG] <= 1'b0;
         frame_reg[`TIMEOUT_CNT_MSB:`TIMEOUT_CNT_LSB] <= 3'h0;
      end
      else if (timeout)
      begin
         frame_reg[`BIT_TIMEOUT_FLAG] <= 1'b1;
         if (timeout_en && frame_reg[`TIMEOUT_CNT_MSB:`TIMEOUT_CNT_LSB]
             != `TIMEOUT_CNT_MAX)
            frame_reg[`TIMEOUT_CNT_MSB:`TIMEOUT_CNT_LSB] <=
               frame_reg[`TIMEOUT_CNT_MSB:`TIMEOUT_CNT_LSB] + 3'h1;
      end
      // Frame kept across timeouts, low speed leaves it alone
      if (sof && full_speed)
         frame_reg[`FRAME_MSB:0] <= frame_in;
      frame_reg[11] <= 1'b0;
   end
end

endmodule // frame_timeout_unit

// *** tb/usb_status_props.sv ***
// Purpose: Port checks of the status and frame number registers.
// Assumes: Bound to the top module; read data lags rd by one cycle.
// Notes:   Irq lags its event by two cycles.
`timescale 1ns/100ps
`include "usb_dev_status_map.vh"
module usb_status_props
(
   input wire ref_clk,
   input wire rst,
   input wire [15:0] cpu_addr,
   input wire cpu_rd,
   input wire [15:0] cpu_rdata,
   input wire [15:0] host_parallel_port_addr,
   input wire host_parallel_port_rd,
   input wire [15:0] host_parallel_port_rdata,
   input wire [7:0] dev2_endpoint_n_done,
   input wire dev1_bus_reset,
   input wire dev1_sof,
   input wire [10:0] dev1_frame_in,
   input wire dev1_full_speed,
   input wire [15:0] dev1_int_enable,
   input wire [15:0] dev2_int_enable,
   input wire dev1_irq,
   input wire dev2_irq
);
   wire cpu_mapped;
   assign cpu_mapped = cpu_addr == `ADDR_STATUS_DEV1 ||
      cpu_addr == `ADDR_FRAME_DEV1 || cpu_addr == `ADDR_STATUS_DEV2 ||
      cpu_addr == `ADDR_FRAME_DEV2;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Read port
   // ----------------------------------------
   a_cpu_idle_zero: assert property (!$past(cpu_rd) |->
      cpu_rdata == 16'h0000) else $error("cpu read data not idle");
   a_host_idle_zero: assert property (
      !$past(host_parallel_port_rd) |->
      host_parallel_port_rdata == 16'h0000) else $error("host data not idle");
   a_unmapped_zero: assert property (cpu_rd && !cpu_mapped |=>
      cpu_rdata == 16'h0000) else $error("unmapped read not zero");
   a_reserved_one: assert property (cpu_rd &&
      cpu_addr == `ADDR_STATUS_DEV1 |=> cpu_rdata[13:10] == 4'h0)
      else $error("unit one reserved bits set");
   a_reserved_two: assert property (host_parallel_port_rd &&
      host_parallel_port_addr == `ADDR_STATUS_DEV2 |=>
      host_parallel_port_rdata[15:10] == 6'h00)
      else $error("unit two reserved bits set");
   a_frame_gap: assert property (cpu_rd &&
      cpu_addr == `ADDR_FRAME_DEV1 |=> cpu_rdata[11] == 1'b0)
      else $error("frame bit 11 set");
   a_frame_capture: assert property (dev1_sof && dev1_full_speed ##1
      (cpu_rd && cpu_addr == `ADDR_FRAME_DEV1) |=>
      cpu_rdata[10:0] == $past(dev1_frame_in, 2))
      else $error("frame number not captured");
   // ----------------------------------------
   // Interrupt requests
   // ----------------------------------------
   a_reset_irq: assert property (
      dev1_bus_reset && dev1_int_enable[8] ##1 dev1_int_enable[8] |=>
      dev1_irq) else $error("bus reset irq late");
   a_ep_irq: assert property (dev2_endpoint_n_done[0] &&
      dev2_int_enable[0] ##1 dev2_int_enable[0] |=> dev2_irq)
      else $error("endpoint irq late");
   a_irq_masked: assert property ($past(dev1_int_enable) == 16'h0000
      |-> !dev1_irq) else $error("irq while disabled");
endmodule // usb_status_props
bind usb_device_status_frame_regs usb_status_props u_props (.*);

// *** tb/otg_pin_model.sv ***
// Purpose: Far-side source of the supply and identification pin levels.
// Assumes: Flip requests are one-cycle pulses on ref_clk.
// Notes:   Pins start low so reset leaves no edge event pending.
`timescale 1ns/100ps
module otg_pin_model
(
   input wire ref_clk,
   input wire rst,
   input wire flip_supply,
   input wire flip_id,
   output reg supply_above_pin,
   output reg id_pin
);
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         supply_above_pin <= 1'b0;
         id_pin <= 1'b0;
      end
      else
      begin
         supply_above_pin <= supply_above_pin ^ flip_supply;
         id_pin <= id_pin ^ flip_id;
      end
   end
endmodule // otg_pin_model

// *** tb/testbench.sv ***
// Purpose: Self-checking bench of the status and frame registers.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes:   Small reload count keeps the timeout scenario short.
`timescale 1ns/100ps
`include "usb_dev_status_map.vh"
module testbench;
   reg ref_clk = 1'b0;
   reg rst = 1'b1;
   reg [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000;
   reg [15:0] host_parallel_port_addr = 16'h0000;
   reg [15:0] host_parallel_port_wdata = 16'h0000;
   reg cpu_wr = 1'b0, cpu_rd = 1'b0;
   reg host_parallel_port_wr = 1'b0, host_parallel_port_rd = 1'b0;
   reg [7:0] dev1_endpoint_n_done = 8'h00, dev2_endpoint_n_done = 8'h00;
   reg [7:0] dev1_endpoint_n_nak = 8'h00, dev2_endpoint_n_nak = 8'h00;
   reg [7:0] dev1_nak_event_enable = 8'h00, dev2_nak_event_enable = 8'h00;
   reg dev1_bus_reset = 1'b0, dev1_sof = 1'b0, dev1_eop = 1'b0;
   reg dev2_bus_reset = 1'b0, dev2_sof = 1'b0, dev2_eop = 1'b0;
   reg [10:0] dev1_frame_in = 11'h000, dev2_frame_in = 11'h000;
   reg dev1_full_speed = 1'b0, dev2_full_speed = 1'b0;
   reg [13:0] dev1_sof_count = 14'h2EE0, dev2_sof_count = 14'h2EE0;
   reg [15:0] dev1_int_enable = 16'h0000, dev2_int_enable = 16'h0000;
   reg flip_supply = 1'b0, flip_id = 1'b0;
   wire [15:0] cpu_rdata, host_parallel_port_rdata;
   wire supply_above_pin, id_pin, dev1_irq, dev2_irq;
   integer n_fail = 0;
   integer tests_run = 0;
   integer k;
   reg [15:0] d;
   reg [15:0] a;

   always #4 ref_clk = ~ref_clk;

   usb_device_status_frame_regs dut (.*);
   otg_pin_model pins (.ref_clk(ref_clk), .rst(rst),
      .flip_supply(flip_supply), .flip_id(flip_id),
      .supply_above_pin(supply_above_pin), .id_pin(id_pin));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task check(input [15:0] got, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp)
         begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask

   task bus_rd(input host, input [15:0] ad, output [15:0] v);
      begin
         @(posedge ref_clk);
         cpu_addr <= ad;
         host_parallel_port_addr <= ad;
         cpu_rd <= !host;
         host_parallel_port_rd <= host;
         @(posedge ref_clk);
         cpu_rd <= 1'b0;
         host_parallel_port_rd <= 1'b0;
         #1 v = host ? host_parallel_port_rdata : cpu_rdata;
      end
   endtask

   task bus_wr(input host, input [15:0] ad, input [15:0] v);
      begin
         @(posedge ref_clk);
         cpu_addr <= ad;
         host_parallel_port_addr <= ad;
         cpu_wdata <= v;
         host_parallel_port_wdata <= v;
         cpu_wr <= !host;
         host_parallel_port_wr <= host;
         @(posedge ref_clk);
         cpu_wr <= 1'b0;
         host_parallel_port_wr <= 1'b0;
      end
   endtask

   task results;
      begin
         $display("checks %0d mismatches %0d", tests_run, n_fail);
         if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      begin
         a = `ADDR_STATUS_DEV1;
         for (k = 0; k < 5; k = k + 1)
         begin
            bus_rd(k[0], a, d);
            check(d, 16'h0000);
            a = (a == 16'hC094) ? `ADDR_STATUS_DEV2 : a + 16'h0002;
         end
         $display("t_reset done");
      end
   endtask

   task t_endpoints;
      begin
         for (k = 0; k < 8; k = k + 1)
         begin
            @(posedge ref_clk);
            dev1_endpoint_n_done <= 8'h01 << k;
            dev2_endpoint_n_nak <= 8'h01 << k;
            @(posedge ref_clk);
            dev1_endpoint_n_done <= 8'h00;
            dev2_endpoint_n_nak <= 8'h00;
            bus_rd(1'b0, `ADDR_STATUS_DEV1, d);
            check(d, 16'h0001 << k);
            bus_rd(1'b1, `ADDR_STATUS_DEV2, d);
            check(d, 16'h0000);
            bus_wr(1'b1, `ADDR_STATUS_DEV1, 16'h0001 << k);
            bus_rd(1'b1, `ADDR_STATUS_DEV1, d);
            check(d, 16'h0000);
         end
         dev2_nak_event_enable <= 8'h80;
         @(posedge ref_clk);
         dev2_endpoint_n_nak <= 8'hC0;
         @(posedge ref_clk);
         dev2_endpoint_n_nak <= 8'h00;
         bus_rd(1'b0, `ADDR_STATUS_DEV2, d);
         check(d, 16'h0080);
         bus_wr(1'b0, `ADDR_STATUS_DEV2, 16'h0080);
         bus_rd(1'b0, `ADDR_STATUS_DEV2, d);
         check(d, 16'h0000);
         $display("t_endpoints done");
      end
   endtask

   task t_events;
      begin
         dev2_full_speed <= 1'b1;
         dev2_frame_in <= 11'h2C3;
         for (k = 0; k < 3; k = k + 1)
         begin
            @(posedge ref_clk);
            {dev1_bus_reset, dev1_sof, dev1_eop} <= 3'b100 >> k;
            {dev2_bus_reset, dev2_sof, dev2_eop} <= 3'b100 >> k;
            @(posedge ref_clk);
            {dev1_bus_reset, dev1_sof, dev1_eop} <= 3'b000;
            {dev2_bus_reset, dev2_sof, dev2_eop} <= 3'b000;
            a = (k == 0) ? 16'h0100 : 16'h0200;
            bus_rd(1'b0, `ADDR_STATUS_DEV1, d);
            check(d, a);
            bus_rd(1'b1, `ADDR_STATUS_DEV2, d);
            check(d, a);
            bus_wr(1'b0, `ADDR_STATUS_DEV1, 16'h0300);
            bus_wr(1'b1, `ADDR_STATUS_DEV2, 16'h0300);
         end
         // Clearing every flag leaves reserved places zero
         bus_wr(1'b0, `ADDR_STATUS_DEV1, 16'hC3FF);
         bus_rd(1'b0, `ADDR_STATUS_DEV1, d);
         check(d, 16'h0000);
         bus_rd(1'b1, `ADDR_FRAME_DEV2, d);
         check(d, 16'h02C3);
         $display("t_events done");
      end
   endtask

   task t_pins;
      begin
         for (k = 0; k < 4; k = k + 1)
         begin
            @(posedge ref_clk);
            flip_supply <= !k[0];
            flip_id <= k[0];
            @(posedge ref_clk);
            flip_supply <= 1'b0;
            flip_id <= 1'b0;
            repeat (8) @(posedge ref_clk);
            a = k[0] ? 16'h4000 : 16'h8000;
            bus_rd(1'b0, `ADDR_STATUS_DEV1, d);
            check(d, a);
            bus_rd(1'b1, `ADDR_STATUS_DEV2, d);
            check(d, 16'h0000);
            bus_wr(1'b1, `ADDR_STATUS_DEV1, a);
            bus_rd(1'b0, `ADDR_STATUS_DEV1, d);
            check(d, 16'h0000);
         end
         $display("t_pins done");
      end
   endtask

   task t_irq;
      begin
         for (k = 0; k < 2; k = k + 1)
         begin
            dev1_int_enable <= k ? 16'h0000 : 16'h0100;
            dev2_int_enable <= k ? 16'h0000 : 16'h0001;
            @(posedge ref_clk);
            dev1_bus_reset <= 1'b1;
            dev2_endpoint_n_done <= 8'h01;
            @(posedge ref_clk);
            dev1_bus_reset <= 1'b0;
            dev2_endpoint_n_done <= 8'h00;
            @(posedge ref_clk);
            #1 check({14'h0000, dev1_irq, dev2_irq},
               k ? 16'h0000 : 16'h0003);
            bus_rd(1'b0, `ADDR_STATUS_DEV1, d);
            check(d, 16'h0100);
            bus_wr(1'b0, `ADDR_STATUS_DEV1, 16'h0100);
            bus_wr(1'b1, `ADDR_STATUS_DEV2, 16'h0001);
            repeat (2) @(posedge ref_clk);
            #1 check({14'h0000, dev1_irq, dev2_irq}, 16'h0000);
         end
         $display("t_irq done");
      end
   endtask

   task t_frame;
      begin
         dev1_full_speed <= 1'b1;
         dev1_frame_in <= 11'h5A5;
         dev1_sof_count <= 14'h0003;
         dev1_int_enable <= 16'h0800;
         @(posedge ref_clk);
         dev1_sof <= 1'b1;
         @(posedge ref_clk);
         dev1_sof <= 1'b0;
         cpu_rd <= 1'b1;
         cpu_addr <= `ADDR_FRAME_DEV1;
         @(posedge ref_clk);
         cpu_rd <= 1'b0;
         #1 check(cpu_rdata, 16'h05A5);
         d = 16'h0000;
         for (k = 0; k < 60 && d[15] !== 1'b1; k = k + 1)
            bus_rd(1'b0, `ADDR_FRAME_DEV1, d);
         check(d, 16'h95A5);
         if (d[15] !== 1'b1)
            results;
         check({15'h0000, k >= 12 && k <= 24}, 16'h0001);
         repeat (600) @(posedge ref_clk);
         bus_rd(1'b0, `ADDR_FRAME_DEV1, d);
         check(d, 16'hF5A5);
         dev1_full_speed <= 1'b0;
         dev1_frame_in <= 11'h123;
         @(posedge ref_clk);
         dev1_eop <= 1'b1;
         dev1_sof <= 1'b1;
         @(posedge ref_clk);
         dev1_eop <= 1'b0;
         dev1_sof <= 1'b0;
         bus_rd(1'b1, `ADDR_FRAME_DEV1, d);
         check(d, 16'h05A5);
         dev1_int_enable <= 16'h0000;
         repeat (200) @(posedge ref_clk);
         bus_rd(1'b0, `ADDR_FRAME_DEV1, d);
         check({13'h0000, d[14:12]}, 16'h0000);
         dev1_sof_count <= 14'h2EE0;
         $display("t_frame done");
      end
   endtask

   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_endpoints;
      t_events;
      t_pins;
      t_irq;
      t_frame;
      results;
   end
endmodule // testbench
